//--- verilog/iowd_core.sv
// Watchdog action masking, fault status, sync counters and HV pin options
`timescale 1ns/1ps
`default_nettype none

module iowd_core
    import iowd_pkg::*;
#(
    parameter int LINES = LINE_COUNT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fieldbus master register port
    input wire iowd_req_type fb_req,
    output iowd_rsp_type fb_rsp,
    // Control SPI register port
    input wire iowd_req_type ctl_req,
    output iowd_rsp_type ctl_rsp,
    // Startup preload of HV options
    input wire logic preload_valid,
    input wire logic [31:0] preload_data,
    // Other re-trigger sources, one-cycle pulse on this clock
    input wire logic ext_retrigger,
    // I/O lines: pins in, normal control from the I/O logic, pins out
    input wire logic [LINES-1:0] io_in,
    input wire logic [LINES-1:0] normal_out,
    input wire logic [31:0] normal_oe,
    output logic [LINES-1:0] io_out,
    output logic [31:0] io_oe,
    // Analog fault detectors and sync pulse pins
    input wire logic [7:0] hv_output_level_detect,
    input wire logic [7:0] ground_short_detect,
    input wire logic [7:0] supply_short_detect,
    input wire logic sync_pulse_a,
    input wire logic sync_pulse_b,
    // HV pin driver options and watchdog state
    output logic [HV_OPTION_WIDTH-1:0] hv_pin_options,
    output logic timeout_active
);
    // Programmed registers
    logic [63:0] output_force_ff;
    logic [31:0] oe_force_ff;
    logic [63:0] input_retrigger_ff;
    logic [31:0] timeout_length_ff;
    logic [7:0] config_ff;

    // Timer state
    logic [31:0] count_ff;
    logic [31:0] peak_ff;
    logic active_ff;
    logic [3:0] div_ff;

    // Two-stage pin synchronisers
    logic [LINES-1:0] in_meta_ff;
    logic [LINES-1:0] in_sync_ff;
    logic [23:0] hv_meta_ff;
    logic [23:0] hv_sync_ff;
    logic [1:0] sync_meta_ff;
    logic [1:0] sync_sync_ff;

    // Edge history, event counters and pin options
    logic [1:0] sync_prev_ff;
    logic [15:0] sync_a_count_ff;
    logic [15:0] sync_b_count_ff;
    logic cond_prev_ff;
    logic [HV_OPTION_WIDTH-1:0] hv_options_ff;

    // Registered outputs and answers
    logic [LINES-1:0] io_out_ff;
    logic [31:0] io_oe_ff;
    iowd_rsp_type fb_rsp_ff;
    iowd_rsp_type ctl_rsp_ff;

    // Write decode; the control port wins when both write one register
    wire ctl_wr = ctl_req.wr;
    wire fb_wr = fb_req.wr & ~(ctl_req.wr & ctl_req.addr == fb_req.addr);
    wire wr_length = (ctl_wr & ctl_req.addr == IDX_TIMEOUT_LENGTH)
                   | (fb_wr & fb_req.addr == IDX_TIMEOUT_LENGTH);
    wire wr_config_c = ctl_wr & ctl_req.addr == IDX_WD_CONFIG;
    wire wr_config_f = fb_wr & fb_req.addr == IDX_WD_CONFIG;
    wire wr_outf_c = ctl_wr & ctl_req.addr == IDX_OUTPUT_FORCE;
    wire wr_outf_f = fb_wr & fb_req.addr == IDX_OUTPUT_FORCE;
    wire wr_oef_c = ctl_wr & ctl_req.addr == IDX_OE_FORCE;
    wire wr_oef_f = fb_wr & fb_req.addr == IDX_OE_FORCE;
    wire wr_inr_c = ctl_wr & ctl_req.addr == IDX_INPUT_RETRIGGER;
    wire wr_inr_f = fb_wr & fb_req.addr == IDX_INPUT_RETRIGGER;
    wire wr_hvopt = ctl_wr & ctl_req.addr == IDX_HV_OPTIONS;
    wire [63:0] length_wdata = (ctl_wr & ctl_req.addr == IDX_TIMEOUT_LENGTH)
                             ? ctl_req.wdata : fb_req.wdata;

    // Register fields
    wire [LINES-1:0] timeout_output_level =
        output_force_ff[LEVEL_LSB +: LINES];
    wire [LINES-1:0] timeout_output_select =
        output_force_ff[SELECT_LSB +: LINES];
    wire [LINES-1:0] retrigger_input_level =
        input_retrigger_ff[LEVEL_LSB +: LINES];
    wire [LINES-1:0] retrigger_input_select =
        input_retrigger_ff[SELECT_LSB +: LINES];

    // Input condition: every selected line at its level, none selected is false
    // A partial match stays false, so one early line cannot re-trigger alone
    wire [LINES-1:0] line_ok = ~retrigger_input_select
                             | ~(in_sync_ff ^ retrigger_input_level);
    wire cond_now = (&line_ok) & (|retrigger_input_select);
    wire cond_rise = cond_now & ~cond_prev_ff;
    wire cond_fall = ~cond_now & cond_prev_ff;
    wire in_retrigger = config_ff[CFG_IN_EDGE_BIT]
                      ? cond_rise : cond_fall;
    wire retrigger = in_retrigger | ext_retrigger;

    // Timer
    // 25 MHz timer step as a one-cycle enable from the core clock divider
    wire tick = div_ff == TICK_LAST;
    wire wd_enabled = timeout_length_ff != RESET_WORD32;
    wire [31:0] count_inc = count_ff + 32'h0000_0001;
    wire count_step = wd_enabled & tick & ~active_ff & ~retrigger;
    wire reach = count_step & (count_inc >= timeout_length_ff);
    // Persistent mode holds the action until the length is rewritten
    wire release_act = retrigger & ~config_ff[CFG_PERSISTENT_BIT];
    wire [31:0] nxt_count = (wr_length | retrigger | ~wd_enabled)
                          ? RESET_WORD32
                          : (count_step ? count_inc : count_ff);
    wire [31:0] nxt_peak = wr_length ? RESET_WORD32
                         : (nxt_count > peak_ff ? nxt_count : peak_ff);
    // A length write ends any running action and restarts counting
    wire nxt_active = ~wr_length & wd_enabled
                    & (reach | (active_ff & ~release_act));

    // Output forcing while the action is active
    wire [LINES-1:0] force_lines = {LINES{active_ff}} & timeout_output_select;
    wire [LINES-1:0] nxt_io_out = (force_lines & timeout_output_level)
                                | (~force_lines & normal_out);
    wire [31:0] nxt_io_oe = active_ff ? oe_force_ff : normal_oe;

    // Read decode per port
    // Detector bits are synchronised levels, not latched events
    wire [31:0] hv_status = {8'h00, hv_sync_ff};
    wire [31:0] sync_word = {sync_b_count_ff, sync_a_count_ff};
    wire fb_hit_ro = fb_req.addr == IDX_PEAK_COUNT
                   | fb_req.addr == IDX_HV_STATUS
                   | fb_req.addr == IDX_SYNC_COUNTERS;
    wire ctl_hit_ro = ctl_req.addr == IDX_PEAK_COUNT
                    | ctl_req.addr == IDX_HV_STATUS;
    wire fb_hit_wo = fb_req.addr == IDX_TIMEOUT_LENGTH
                   | fb_req.addr == IDX_WD_CONFIG
                   | fb_req.addr == IDX_OUTPUT_FORCE
                   | fb_req.addr == IDX_OE_FORCE
                   | fb_req.addr == IDX_INPUT_RETRIGGER;
    wire ctl_hit_wo = ctl_req.addr == IDX_TIMEOUT_LENGTH
                    | ctl_req.addr == IDX_WD_CONFIG
                    | ctl_req.addr == IDX_OUTPUT_FORCE
                    | ctl_req.addr == IDX_OE_FORCE
                    | ctl_req.addr == IDX_INPUT_RETRIGGER
                    | ctl_req.addr == IDX_HV_OPTIONS;
    wire [31:0] fb_read = fb_req.addr == IDX_PEAK_COUNT ? peak_ff
                        : fb_req.addr == IDX_HV_STATUS ? hv_status
                        : sync_word;
    wire [31:0] ctl_read = ctl_req.addr == IDX_PEAK_COUNT ? peak_ff
                         : hv_status;
    wire fb_ok = (fb_req.rd & fb_hit_ro) | (fb_req.wr & fb_hit_wo);
    wire ctl_ok = (ctl_req.rd & ctl_hit_ro) | (ctl_req.wr & ctl_hit_wo);
    wire fb_any = fb_req.rd | fb_req.wr;
    wire ctl_any = ctl_req.rd | ctl_req.wr;
    // Refused accesses and writes answer with zero read data
    wire [31:0] fb_rdata = (fb_req.rd & fb_ok) ? fb_read : RESET_WORD32;
    wire [31:0] ctl_rdata = (ctl_req.rd & ctl_ok) ? ctl_read : RESET_WORD32;
    wire iowd_rsp_type nxt_fb_rsp = '{ack: fb_any & fb_ok,
        err: fb_any & ~fb_ok,
        rdata: {32'h0000_0000, fb_rdata}};
    wire iowd_rsp_type nxt_ctl_rsp = '{ack: ctl_any & ctl_ok,
        err: ctl_any & ~ctl_ok,
        rdata: {32'h0000_0000, ctl_rdata}};

    // Pin synchronisers
    // No reset: a reset held for a few edges flushes both stages
    always_ff @(posedge clock) begin
        in_meta_ff <= io_in;
        in_sync_ff <= in_meta_ff;
        hv_meta_ff <= {supply_short_detect, ground_short_detect,
                       hv_output_level_detect};
        hv_sync_ff <= hv_meta_ff;
        sync_meta_ff <= {sync_pulse_b, sync_pulse_a};
        sync_sync_ff <= sync_meta_ff;
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (rst) begin
            output_force_ff <= RESET_WORD64;
            oe_force_ff <= RESET_WORD32;
            input_retrigger_ff <= RESET_WORD64;
            timeout_length_ff <= RESET_WORD32;
            config_ff <= RESET_CONFIG;
            hv_options_ff <= HV_OPTION_WIDTH'(RESET_WORD32);
        end else begin
            if (wr_outf_c | wr_outf_f) begin
                output_force_ff <= wr_outf_c ? ctl_req.wdata : fb_req.wdata;
            end
            if (wr_oef_c | wr_oef_f) begin
                oe_force_ff <= wr_oef_c ? ctl_req.wdata[31:0]
                                        : fb_req.wdata[31:0];
            end
            if (wr_inr_c | wr_inr_f) begin
                input_retrigger_ff <= wr_inr_c ? ctl_req.wdata
                                               : fb_req.wdata;
            end
            if (wr_length) begin
                timeout_length_ff <= length_wdata[31:0];
            end
            if (wr_config_c | wr_config_f) begin
                config_ff <= wr_config_c ? ctl_req.wdata[7:0]
                                         : fb_req.wdata[7:0];
            end
            if (wr_hvopt) begin
                hv_options_ff <= ctl_req.wdata[HV_OPTION_WIDTH-1:0];
            end else if (preload_valid) begin
                hv_options_ff <= preload_data[HV_OPTION_WIDTH-1:0];
            end
        end
    end

    // Timer, peak and action state
    always_ff @(posedge clock) begin
        if (rst) begin
            div_ff <= 4'h0;
            count_ff <= RESET_WORD32;
            peak_ff <= RESET_WORD32;
            active_ff <= 1'b0;
            cond_prev_ff <= 1'b0;
        end else begin
            div_ff <= tick ? 4'h0 : div_ff + 4'h1;
            count_ff <= nxt_count;
            peak_ff <= nxt_peak;
            active_ff <= nxt_active;
            cond_prev_ff <= cond_now;
        end
    end

    // Free-running sync event counters, not touched by reads
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_prev_ff <= 2'h0;
            sync_a_count_ff <= 16'h0000;
            sync_b_count_ff <= 16'h0000;
        end else begin
            sync_prev_ff <= sync_sync_ff;
            if (sync_sync_ff[0] & ~sync_prev_ff[0]) begin
                sync_a_count_ff <= sync_a_count_ff + 16'h0001;
            end
            if (sync_sync_ff[1] & ~sync_prev_ff[1]) begin
                sync_b_count_ff <= sync_b_count_ff + 16'h0001;
            end
        end
    end

    // Registered outputs and answers
    always_ff @(posedge clock) begin
        if (rst) begin
            io_out_ff <= '0;
            io_oe_ff <= RESET_WORD32;
            fb_rsp_ff <= '0;
            ctl_rsp_ff <= '0;
        end else begin
            io_out_ff <= nxt_io_out;
            io_oe_ff <= nxt_io_oe;
            fb_rsp_ff <= nxt_fb_rsp;
            ctl_rsp_ff <= nxt_ctl_rsp;
        end
    end

    // Every output comes straight from its register
    assign io_out = io_out_ff;
    assign io_oe = io_oe_ff;
    assign fb_rsp = fb_rsp_ff;
    assign ctl_rsp = ctl_rsp_ff;
    // Slope, drive strength and differential pairing go straight to pads
    assign hv_pin_options = hv_options_ff;
    assign timeout_active = active_ff;
endmodule // iowd_core

`default_nettype wire

//--- verilog/iowd_pkg.sv
// Shared constants and types of the I/O watchdog action and status block
package iowd_pkg;
    // Register indices; HV options on the control port only, sync counters on the fieldbus port only
    localparam logic [6:0] IDX_TIMEOUT_LENGTH = 7'h35;
    localparam logic [6:0] IDX_WD_CONFIG = 7'h36;
    localparam logic [6:0] IDX_OUTPUT_FORCE = 7'h37;
    localparam logic [6:0] IDX_OE_FORCE = 7'h38;
    localparam logic [6:0] IDX_INPUT_RETRIGGER = 7'h39;
    localparam logic [6:0] IDX_PEAK_COUNT = 7'h3A;
    localparam logic [6:0] IDX_HV_STATUS = 7'h3B;
    localparam logic [6:0] IDX_SYNC_COUNTERS = 7'h3F;
    localparam logic [6:0] IDX_HV_OPTIONS = 7'h40;
    // Field positions inside the 64-bit force and retrigger words
    localparam int LEVEL_LSB = 0;
    localparam int SELECT_LSB = 32;
    localparam int LINE_COUNT = 24;
    // Configuration bits
    localparam int CFG_PERSISTENT_BIT = 0;
    localparam int CFG_IN_EDGE_BIT = 4;
    localparam int CFG_ACTIVE_BIT = 7;
    // Sync counter halves and high-voltage option fields
    localparam int SYNC_A_LSB = 0;
    localparam int SYNC_B_LSB = 16;
    localparam int DIFF_PAIR_LSB = 24;
    localparam int HV_OPTION_WIDTH = 28;
    // Reset values
    localparam logic [63:0] RESET_WORD64 = 64'h0000_0000_0000_0000;
    localparam logic [31:0] RESET_WORD32 = 32'h0000_0000;
    localparam logic [7:0] RESET_CONFIG = 8'h00;
    // Timer tick: 25 MHz derived from the 200 MHz core clock
    localparam int CORE_CLOCK_KHZ = 200000;
    localparam int TIMER_CLOCK_KHZ = 25000;
    localparam int TICK_DIVIDE = CORE_CLOCK_KHZ / TIMER_CLOCK_KHZ;
    localparam logic [3:0] TICK_LAST = 4'(TICK_DIVIDE - 1);

    // One register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [63:0] wdata;
    } iowd_req_type;

    // One register access answer
    typedef struct packed {
        logic ack;
        logic err;
        logic [63:0] rdata;
    } iowd_rsp_type;
endpackage

//--- tb/iowd_host_model.sv
// Register port master model for the fieldbus and control sides
`timescale 1ns/1ps
`default_nettype none

module iowd_host_model
    import iowd_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output var iowd_req_type req,
    input wire iowd_rsp_type rsp
);
    initial req = '0;

    // Request held over its taking edge, answer sampled while it stands
    task automatic access(input logic wr, input logic [6:0] addr,
                          input logic [63:0] wdata, output iowd_rsp_type got);
        @(negedge clock);
        req.wr = wr;
        req.rd = !wr;
        req.addr = addr;
        req.wdata = wdata;
        @(negedge clock);
        got = rsp;
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask
endmodule // iowd_host_model

`default_nettype wire

//--- tb/iowd_core_properties.sv
// Port-level properties of the I/O watchdog action and status block
`timescale 1ns/1ps
`default_nettype none

module iowd_core_properties
    import iowd_pkg::*;
#(
    parameter int LINES = LINE_COUNT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register ports
    input wire iowd_req_type fb_req,
    input wire iowd_rsp_type fb_rsp,
    input wire iowd_req_type ctl_req,
    input wire iowd_rsp_type ctl_rsp,
    // Preload and retrigger
    input wire logic preload_valid,
    input wire logic [31:0] preload_data,
    input wire logic ext_retrigger,
    // Lines
    input wire logic [LINES-1:0] io_in,
    input wire logic [LINES-1:0] normal_out,
    input wire logic [31:0] normal_oe,
    input wire logic [LINES-1:0] io_out,
    input wire logic [31:0] io_oe,
    // Detectors and sync pins
    input wire logic [7:0] hv_output_level_detect,
    input wire logic [7:0] ground_short_detect,
    input wire logic [7:0] supply_short_detect,
    input wire logic sync_pulse_a,
    input wire logic sync_pulse_b,
    // Options and state
    input wire logic [HV_OPTION_WIDTH-1:0] hv_pin_options,
    input wire logic timeout_active
);
    wire logic ctl_opt_wr = ctl_req.wr && ctl_req.addr == IDX_HV_OPTIONS;
    wire logic fb_opt = (fb_req.wr || fb_req.rd) &&
        fb_req.addr == IDX_HV_OPTIONS;
    wire logic ctl_len_wr = ctl_req.wr && ctl_req.addr == IDX_TIMEOUT_LENGTH;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    AST_FB_OPTIONS_REFUSED: assert property (fb_opt |=> fb_rsp.err)
        else $error("fieldbus options access not refused");
    AST_FB_OPTIONS_KEPT: assert property (
        fb_opt && !ctl_opt_wr && !preload_valid |=> $stable(hv_pin_options))
        else $error("fieldbus access changed options");
    AST_CTL_OPTIONS_WRITE: assert property (ctl_opt_wr |=>
        hv_pin_options == $past(ctl_req.wdata[27:0]))
        else $error("control options write not applied");
    AST_PRELOAD: assert property (preload_valid && !ctl_opt_wr |=>
        hv_pin_options == $past(preload_data[27:0]))
        else $error("preload not applied");
    AST_CTL_SYNC_REFUSED: assert property (
        ctl_req.rd && ctl_req.addr == IDX_SYNC_COUNTERS |=>
        ctl_rsp.err && !ctl_rsp.ack)
        else $error("control sync read not refused");
    AST_FB_SYNC_READ: assert property (
        fb_req.rd && fb_req.addr == IDX_SYNC_COUNTERS |=>
        fb_rsp.ack && fb_rsp.rdata[63:32] == 32'h0)
        else $error("fieldbus sync read malformed");
    AST_NORMAL_PATH: assert property (!timeout_active |=>
        io_out == $past(normal_out) && io_oe == $past(normal_oe))
        else $error("lines not under normal control");
    AST_LENGTH_ZERO: assert property (
        ctl_len_wr && ctl_req.wdata[31:0] == 32'h0 |=> !timeout_active [*8])
        else $error("watchdog active with zero length");
    AST_PEAK_CLEARED: assert property (ctl_len_wr ##2
        (ctl_req.rd && ctl_req.addr == IDX_PEAK_COUNT) |=>
        ctl_rsp.rdata[63:1] == 63'h0)
        else $error("peak not cleared by length write");

    COV_TIMEOUT: cover property ($rose(timeout_active));
    COV_RETRIGGER: cover property ($fell(timeout_active));
    COV_FB_REFUSED: cover property (fb_rsp.err);
endmodule // iowd_core_properties

bind iowd_core iowd_core_properties #(.LINES(LINES)) u_iowd_core_properties (
    .clock, .rst, .fb_req, .fb_rsp, .ctl_req, .ctl_rsp, .preload_valid,
    .preload_data, .ext_retrigger, .io_in, .normal_out, .normal_oe, .io_out,
    .io_oe, .hv_output_level_detect, .ground_short_detect,
    .supply_short_detect, .sync_pulse_a, .sync_pulse_b, .hv_pin_options,
    .timeout_active);

`default_nettype wire

//--- tb/iowd_core_bench.sv
// Self-checking bench of the I/O watchdog action and status block
`timescale 1ns/1ps
`default_nettype none

module iowd_core_bench;
    import iowd_pkg::*;
    logic clock, rst, preload_valid, ext_retrigger, sync_pulse_a, sync_pulse_b;
    logic [31:0] preload_data, normal_oe, io_oe;
    logic [23:0] io_in, normal_out, io_out;
    logic [7:0] hv_output_level_detect, ground_short_detect, supply_short_detect;
    logic [27:0] hv_pin_options;
    logic timeout_active;
    iowd_req_type fb_req, ctl_req;
    iowd_rsp_type fb_rsp, ctl_rsp, got;
    int failures = 0;
    int comparisons = 0;

    iowd_core u_iowd_core (.clock, .rst, .fb_req, .fb_rsp, .ctl_req, .ctl_rsp,
        .preload_valid, .preload_data, .ext_retrigger, .io_in, .normal_out,
        .normal_oe, .io_out, .io_oe, .hv_output_level_detect,
        .ground_short_detect, .supply_short_detect, .sync_pulse_a,
        .sync_pulse_b, .hv_pin_options, .timeout_active);
    iowd_host_model u_fb_host (.clock, .req(fb_req), .rsp(fb_rsp));
    iowd_host_model u_ctl_host (.clock, .req(ctl_req), .rsp(ctl_rsp));

    task automatic check(input string what, input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wait_active(input logic lvl);
        repeat (100) if (timeout_active !== lvl) @(negedge clock);
    endtask

    task automatic summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic test_hv_options;
        preload_data = 32'hF123_4567;
        preload_valid = 1'b1;
        cycles(1);
        preload_valid = 1'b0;
        check("preload", 64'(hv_pin_options), 64'h0123_4567);
        u_ctl_host.access(1'b1, IDX_HV_OPTIONS, 64'h0ABC_DEF1, got);
        check("options", 64'(hv_pin_options), 64'h0ABC_DEF1);
        u_fb_host.access(1'b1, IDX_HV_OPTIONS, 64'h0, got);
        check("fb options err", 64'(got.err), 64'h1);
        check("options kept", 64'(hv_pin_options), 64'h0ABC_DEF1);
        $display("test hv_options done");
    endtask

    task automatic test_status_sync;
        hv_output_level_detect = 8'hA5;
        ground_short_detect = 8'h3C;
        supply_short_detect = 8'h81;
        for (int i = 0; i < 3; i++) begin
            sync_pulse_a = 1'b1;
            sync_pulse_b = (i < 2);
            cycles(2);
            sync_pulse_a = 1'b0;
            sync_pulse_b = 1'b0;
            cycles(2);
        end
        cycles(3);
        u_ctl_host.access(1'b0, IDX_HV_STATUS, 64'h0, got);
        check("hv status", got.rdata, 64'h0081_3CA5);
        repeat (2) begin
            u_fb_host.access(1'b0, IDX_SYNC_COUNTERS, 64'h0, got);
            check("sync counters", got.rdata, 64'h0002_0003);
        end
        u_ctl_host.access(1'b0, IDX_SYNC_COUNTERS, 64'h0, got);
        check("ctl sync err", 64'(got.err), 64'h1);
        $display("test status_sync done");
    endtask

    task automatic test_timeout;
        u_ctl_host.access(1'b1, IDX_OUTPUT_FORCE, 64'h0000_FFFF_00F0_F0F0, got);
        u_ctl_host.access(1'b1, IDX_OE_FORCE, 64'h5A5A, got);
        u_ctl_host.access(1'b1, IDX_TIMEOUT_LENGTH, 64'h4, got);
        wait_active(1'b1);
        cycles(2);
        check("forced out", 64'(io_out), 64'h12_F0F0);
        check("forced oe", 64'(io_oe[15:0]), 64'h5A5A);
        u_fb_host.access(1'b0, IDX_PEAK_COUNT, 64'h0, got);
        check("peak", got.rdata, 64'h4);
        u_ctl_host.access(1'b1, IDX_TIMEOUT_LENGTH, 64'h0, got);
        u_ctl_host.access(1'b0, IDX_PEAK_COUNT, 64'h0, got);
        check("peak cleared", got.rdata, 64'h0);
        cycles(64);
        check("disabled", 64'(timeout_active), 64'h0);
        check("normal out", 64'(io_out), 64'h12_3456);
        check("normal oe", 64'(io_oe), 64'hFFFF_FFFF);
        $display("test timeout done");
    endtask

    task automatic test_retrigger;
        u_ctl_host.access(1'b1, IDX_WD_CONFIG, 64'h10, got);
        u_ctl_host.access(1'b1, IDX_INPUT_RETRIGGER, 64'h3_0000_0003, got);
        u_ctl_host.access(1'b1, IDX_TIMEOUT_LENGTH, 64'h4, got);
        wait_active(1'b1);
        io_in = 24'h00_0005;
        cycles(6);
        check("partial match", 64'(timeout_active), 64'h1);
        io_in = 24'h00_0007;
        wait_active(1'b0);
        check("retriggered", 64'(timeout_active), 64'h0);
        $display("test retrigger done");
    endtask

    task automatic test_fall_persist;
        u_ctl_host.access(1'b1, IDX_WD_CONFIG, 64'h00, got);
        u_ctl_host.access(1'b1, IDX_TIMEOUT_LENGTH, 64'h4, got);
        wait_active(1'b1);
        io_in = 24'h00_0001;
        wait_active(1'b0);
        check("fall retrigger", 64'(timeout_active), 64'h0);
        u_ctl_host.access(1'b1, IDX_WD_CONFIG, 64'h01, got);
        wait_active(1'b1);
        ext_retrigger = 1'b1;
        cycles(1);
        ext_retrigger = 1'b0;
        cycles(4);
        check("persistent", 64'(timeout_active), 64'h1);
        check("still forced", 64'(io_out), 64'h12_F0F0);
        u_ctl_host.access(1'b1, IDX_TIMEOUT_LENGTH, 64'h0, got);
        cycles(2);
        check("length write ends", 64'(timeout_active), 64'h0);
        check("released out", 64'(io_out), 64'h12_3456);
        $display("test fall_persist done");
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        rst = 1'b1;
        {preload_valid, ext_retrigger, sync_pulse_a, sync_pulse_b} = 4'h0;
        preload_data = 32'h0;
        io_in = 24'h0;
        normal_out = 24'h12_3456;
        normal_oe = 32'hFFFF_FFFF;
        hv_output_level_detect = 8'h0;
        ground_short_detect = 8'h0;
        supply_short_detect = 8'h0;
        cycles(10);
        rst = 1'b0;
        test_hv_options;
        test_status_sync;
        test_timeout;
        test_retrigger;
        test_fall_persist;
        summarize;
    end

    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        summarize;
    end
endmodule // iowd_core_bench

`default_nettype wire
